/* File: mft_ctrl.sv */
/*
  FIFO threshold control for a MAC with internal receive and transmit FIFOs.
  Network side presents receive words with valid/sop/eop/err; user side drains them.
  User side writes transmit words; network side gets one word per cycle when enabled.
  Pause frame requests are one-cycle pulses toward an external pause generator.
*/
`timescale 1ns/1ps
`default_nettype none
module mft_ctrl
  import mft_pkg::*;
#(
  parameter int unsigned DW = MFT_DATA_W,   // 8 or 32; levels count entries of this width
  parameter int unsigned LG = MFT_DEPTH_LG
) (
  // Clock and reset
  input  wire logic            core_clk_in,
  input  wire logic            sys_rst_in,
  // Threshold levels and errored-frame drop control
  input  wire logic [LG:0]     rx_almost_empty_in,
  input  wire logic [LG:0]     rx_almost_full_in,
  input  wire logic [LG:0]     rx_section_empty_in,
  input  wire logic [LG:0]     rx_section_full_in,
  input  wire logic [LG:0]     tx_almost_empty_in,
  input  wire logic [LG:0]     tx_almost_full_in,
  input  wire logic [LG:0]     tx_section_empty_in,
  input  wire logic [LG:0]     tx_section_full_in,
  input  wire logic            drop_errored_frames_ctl,
  // Network receive stream
  input  wire logic            net_rx_valid_in,
  input  wire logic [DW-1:0]   net_rx_data_in,
  input  wire logic            net_rx_sop_in,
  input  wire logic            net_rx_eop_in,
  input  wire logic            net_rx_err_in,
  // User receive stream
  input  wire logic            rcv_sink_accepting,
  output logic                 rcv_data_valid_out,
  output logic      [DW-1:0]   rcv_data_out,
  output logic                 rcv_start_of_packet_out,
  output logic                 rcv_end_of_packet_out,
  output logic [MFT_ERR_W-1:0] rcv_error_out,
  output logic                 rcv_data_available_out,
  output logic                 rcv_nearly_empty_flag,
  output logic                 rcv_nearly_full_flag,
  // Pause requests
  output logic                 xoff_request_out,
  output logic                 xon_request_out,
  // User transmit stream
  input  wire logic            xmt_valid_in,
  input  wire logic [DW-1:0]   xmt_data_in,
  input  wire logic            xmt_sop_in,
  input  wire logic            xmt_eop_in,
  output logic                 xmt_accept_out,
  output logic                 xmt_nearly_empty_flag,
  output logic                 xmt_nearly_full_flag,
  output logic                 xmt_room_warning_out,
  // Network transmit side
  output logic                 net_tx_en_out,
  output logic      [DW-1:0]   net_tx_data_out,
  output logic                 net_tx_err_out
);
  localparam int unsigned FW    = DW + 3;   // data, sop, eop, err
  localparam int unsigned DEPTH = 1 << LG;
  localparam logic [LG:0] DEPTH_L = DEPTH[LG:0];
  localparam int unsigned B_SOP = DW;
  localparam int unsigned B_EOP = DW + 1;
  localparam int unsigned B_ERR = DW + 2;

  // Threshold compare used by both directions
  function automatic logic at_or_below(input logic [LG:0] v, input logic [LG:0] lvl);
    return v <= lvl;
  endfunction

  // Frame-end counter step shared by both directions
  function automatic logic [LG:0] step_count(input logic [LG:0] cnt, input logic up,
                                             input logic down);
    return (up && !down) ? cnt + 1'b1 : ((!up && down) ? cnt - 1'b1 : cnt);
  endfunction

  // ---------------- Receive path ----------------
  logic [FW-1:0] rxf_wdata, rxf_rdata;
  logic [LG:0]   rxf_lvl;
  logic          rxf_wr, rxf_rd;
  logic [LG:0]   rx_free;
  logic          rx_sf_mode;
  logic          rx_truncating_reg, rx_truncating_next;
  logic          rx_in_frame_reg, rx_in_frame_next;
  logic [LG:0]   rx_eops_reg, rx_eops_next;     // Whole frames held in receive FIFO
  logic          rx_head_err;                   // Error mark of the oldest stored frame
  logic          rx_cut_eop;
  logic          rx_sec_reg, rx_sec_next;
  logic          rx_xoff_pend_reg, rx_xoff_pend_next;
  logic          rx_xon_pend_reg, rx_xon_pend_next;
  logic          rx_may_read;
  logic          rx_out_v_reg, rx_out_v_next;
  logic [FW-1:0] rx_out_reg, rx_out_next;
  logic          rx_out_cut_reg, rx_out_cut_next;
  logic          tx_busy;

  assign rx_free    = DEPTH_L - rxf_lvl;
  assign rx_sf_mode = (rx_section_full_in == MFT_LVL_ZERO[LG:0]);

  // Flags recomputed every cycle from level or free space
  assign rcv_nearly_empty_flag  = at_or_below(rxf_lvl, rx_almost_empty_in);
  assign rcv_nearly_full_flag   = at_or_below(rx_free, rx_almost_full_in);
  assign rcv_data_available_out = !rx_sf_mode && (rxf_lvl >= rx_section_full_in);

  // Write side: truncate while nearly full and sink stalled; cut frame gets a forced eop
  always_comb begin
    rx_truncating_next = rx_truncating_reg;
    rx_in_frame_next   = rx_in_frame_reg;
    rxf_wr             = 1'b0;
    rx_cut_eop         = 1'b0;
    rxf_wdata          = {net_rx_err_in, net_rx_eop_in, net_rx_sop_in, net_rx_data_in};
    if (net_rx_valid_in) begin
      if (net_rx_sop_in) begin
        rx_truncating_next = 1'b0;
        rx_in_frame_next   = 1'b1;
      end
      if (rx_truncating_reg && !net_rx_sop_in) begin
        rxf_wr = 1'b0;
      end else if (rcv_nearly_full_flag && !rcv_sink_accepting && rxf_lvl < DEPTH_L) begin
        rxf_wr             = 1'b1;                                 // Last word closes frame
        rx_cut_eop         = 1'b1;
        rxf_wdata[B_EOP]   = 1'b1;
        rxf_wdata[B_ERR]   = 1'b1;
        rx_truncating_next = !net_rx_eop_in;
        rx_in_frame_next   = 1'b0;
      end else if (rxf_lvl < DEPTH_L && (rx_in_frame_reg || net_rx_sop_in)) begin
        rxf_wr = 1'b1;
        if (net_rx_eop_in) begin
          rx_in_frame_next = 1'b0;
        end
      end
    end
  end

  // Frames-complete counter for end-of-packet detection and store-and-forward
  assign rx_eops_next = step_count(rx_eops_reg, rxf_wr && rxf_wdata[B_EOP],
                                   rxf_rd && rxf_rdata[B_EOP]);

  // Reading: stop at almost-empty unless a frame end is already stored
  always_comb begin
    rx_may_read = (rxf_lvl != '0) && (!rcv_nearly_empty_flag || rx_eops_reg != '0);
    if (rx_sf_mode) begin
      rx_may_read = (rxf_lvl != '0) && (rx_eops_reg != '0);
    end
    rxf_rd = rx_may_read && (!rx_out_v_reg || rcv_sink_accepting);
  end

  // Output register and error-frame discard
  always_comb begin
    rx_out_v_next    = rx_out_v_reg && !rcv_sink_accepting;
    rx_out_next      = rx_out_reg;
    rx_out_cut_next  = rx_out_cut_reg;
    if (rxf_rd) begin
      rx_out_next     = rxf_rdata;
      rx_out_cut_next = rxf_rdata[B_ERR];
      rx_out_v_next   = 1'b1;
      // Whole frames are stored before reading here, so the error mark of the
      // oldest frame is known from its first word on and every word is dropped
      if (drop_errored_frames_ctl && rx_sf_mode && rx_head_err) begin
        rx_out_v_next = 1'b0;
      end
    end
  end

  // Pause requests: edge of section-empty crossing, XOFF and XON held while transmitting
  always_comb begin
    rx_sec_next       = !at_or_below(rxf_lvl, rx_section_empty_in - MFT_LVL_ONE[LG:0]);
    rx_xoff_pend_next = rx_xoff_pend_reg;
    rx_xon_pend_next  = rx_xon_pend_reg;
    if (rx_sec_next && !rx_sec_reg) begin
      rx_xoff_pend_next = 1'b1;
      rx_xon_pend_next  = 1'b0;
    end else if (!rx_sec_next && rx_sec_reg) begin
      rx_xon_pend_next  = 1'b1;
      rx_xoff_pend_next = 1'b0;
    end else if (!tx_busy) begin
      rx_xoff_pend_next = 1'b0;
      rx_xon_pend_next  = 1'b0;
    end
  end
  assign xoff_request_out = rx_xoff_pend_reg && !tx_busy;
  assign xon_request_out  = rx_xon_pend_reg && !tx_busy;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rx_truncating_reg <= 1'b0;
      rx_in_frame_reg   <= 1'b0;
      rx_eops_reg       <= '0;
      rx_sec_reg        <= 1'b0;
      rx_xoff_pend_reg  <= 1'b0;
      rx_xon_pend_reg   <= 1'b0;
      rx_out_v_reg      <= 1'b0;
      rx_out_reg        <= '0;
      rx_out_cut_reg    <= 1'b0;
    end else begin
      rx_truncating_reg <= rx_truncating_next;
      rx_in_frame_reg   <= rx_in_frame_next;
      rx_eops_reg       <= rx_eops_next;
      rx_sec_reg        <= rx_sec_next;
      rx_xoff_pend_reg  <= rx_xoff_pend_next;
      rx_xon_pend_reg   <= rx_xon_pend_next;
      rx_out_v_reg      <= rx_out_v_next;
      rx_out_reg        <= rx_out_next;
      rx_out_cut_reg    <= rx_out_cut_next;
    end
  end

  // User receive outputs
  always_comb begin
    rcv_data_valid_out      = rx_out_v_reg;
    rcv_data_out            = rx_out_reg[DW-1:0];
    rcv_start_of_packet_out = rx_out_reg[B_SOP];
    rcv_end_of_packet_out   = rx_out_reg[B_EOP];
    rcv_error_out           = '0;
    rcv_error_out[MFT_ERR_TRUNC] = rx_out_cut_reg && rx_out_reg[B_EOP];
    rcv_error_out[MFT_ERR_INVAL] = rx_out_cut_reg;
  end

  mft_fifo #(.W(FW), .LG(LG)) u_rx_fifo (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .wr_in       (rxf_wr),
    .wdata_in    (rxf_wdata),
    .rd_in       (rxf_rd),
    .rdata_out   (rxf_rdata),
    .level_out   (rxf_lvl)
  );
  // Error mark per stored frame: pushed when its end is written, popped when it is read
  mft_fifo #(.W(1), .LG(LG)) u_rx_ferr (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .wr_in(rxf_wr && rxf_wdata[B_EOP]), .wdata_in(rxf_wdata[B_ERR]),
    .rd_in(rxf_rd && rxf_rdata[B_EOP]), .rdata_out(rx_head_err), .level_out());

  // ---------------- Transmit path ----------------
  logic [FW-1:0]  txf_rdata;
  logic [LG:0]    txf_lvl, tx_free;
  logic           txf_wr, txf_rd;
  logic [LG:0]    tx_eops_reg, tx_eops_next;
  mft_tx_state_t  tx_st_reg, tx_st_next;
  logic           tx_en_reg, tx_en_next, tx_err_reg, tx_err_next;
  logic [DW-1:0]  tx_d_reg, tx_d_next;
  logic           tx_start_ok;

  assign tx_free               = DEPTH_L - txf_lvl;
  assign xmt_nearly_empty_flag = at_or_below(txf_lvl, tx_almost_empty_in);
  assign xmt_nearly_full_flag  = at_or_below(tx_free, tx_almost_full_in);
  assign xmt_accept_out        = !xmt_nearly_full_flag && (tx_free != '0);
  assign xmt_room_warning_out  = txf_lvl < tx_section_empty_in;
  assign txf_wr                = xmt_valid_in && xmt_accept_out;
  assign tx_busy               = (tx_st_reg != MFT_TX_IDLE);

  // Start condition: a whole frame stored in either mode, or the fill threshold when it is not zero
  assign tx_start_ok = (tx_eops_reg != '0)
                    || ((tx_section_full_in != MFT_LVL_ZERO[LG:0])
                        && (txf_lvl >= tx_section_full_in));

  // Stored frame ends on transmit side
  assign tx_eops_next = step_count(tx_eops_reg, txf_wr && xmt_eop_in,
                                   txf_rd && txf_rdata[B_EOP]);

  // Transmit sequencer with underflow handling
  always_comb begin
    tx_st_next  = tx_st_reg;
    tx_en_next  = 1'b0;
    tx_err_next = 1'b0;
    tx_d_next   = tx_d_reg;
    txf_rd      = 1'b0;
    unique case (tx_st_reg)
      MFT_TX_IDLE: begin
        if (txf_lvl != '0 && !txf_rdata[B_SOP]) begin
          txf_rd = 1'b1;                                           // Stray words before a start
        end else if (txf_lvl != '0 && tx_start_ok) begin
          txf_rd     = 1'b1;
          tx_en_next = 1'b1;
          tx_d_next  = txf_rdata[DW-1:0];
          tx_st_next = txf_rdata[B_EOP] ? MFT_TX_IDLE : MFT_TX_SEND;
        end
      end
      MFT_TX_SEND: begin
        if (xmt_nearly_empty_flag && tx_eops_reg == '0) begin
          tx_en_next  = 1'b1;
          tx_err_next = 1'b1;
          tx_st_next  = MFT_TX_DISCARD;
        end else if (txf_lvl != '0) begin
          txf_rd     = 1'b1;
          tx_en_next = 1'b1;
          tx_d_next  = txf_rdata[DW-1:0];
          if (txf_rdata[B_EOP]) begin
            tx_st_next = MFT_TX_IDLE;
          end
        end
      end
      MFT_TX_DISCARD: begin
        if (txf_lvl != '0) begin
          txf_rd = 1'b1;
          if (txf_rdata[B_EOP]) begin
            tx_st_next = MFT_TX_IDLE;
          end
        end
      end
      default: tx_st_next = MFT_TX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      tx_st_reg   <= MFT_TX_IDLE;
      tx_eops_reg <= '0;
      tx_en_reg   <= 1'b0;
      tx_err_reg  <= 1'b0;
      tx_d_reg    <= '0;
    end else begin
      tx_st_reg   <= tx_st_next;
      tx_eops_reg <= tx_eops_next;
      tx_en_reg   <= tx_en_next;
      tx_err_reg  <= tx_err_next;
      tx_d_reg    <= tx_d_next;
    end
  end

  assign net_tx_en_out   = tx_en_reg;
  assign net_tx_err_out  = tx_err_reg;
  assign net_tx_data_out = tx_d_reg;

  mft_fifo #(.W(FW), .LG(LG)) u_tx_fifo (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .wr_in       (txf_wr),
    .wdata_in    ({1'b0, xmt_eop_in, xmt_sop_in, xmt_data_in}),
    .rd_in       (txf_rd),
    .rdata_out   (txf_rdata),
    .level_out   (txf_lvl)
  );
endmodule
`default_nettype wire

/* File: mft_pkg.sv */
/*
  Package for the FIFO threshold control block: widths, level defaults, error bit positions.
  Assumes the two FIFOs themselves live in the main module and share one clock.
*/
package mft_pkg;
  localparam int unsigned MFT_DATA_W   = 32;
  localparam int unsigned MFT_DEPTH_LG = 6;
  localparam int unsigned MFT_LVL_W    = MFT_DEPTH_LG + 1;
  // Error bit positions on the receive side
  localparam int unsigned MFT_ERR_W      = 4;
  localparam int unsigned MFT_ERR_TRUNC  = 0;
  localparam int unsigned MFT_ERR_INVAL  = 3;
  // Neutral reset value for all levels
  localparam logic [MFT_LVL_W-1:0] MFT_LVL_ZERO = 7'h00;
  localparam logic [MFT_LVL_W-1:0] MFT_LVL_ONE  = 7'h01;

  // Transmit side frame state, Gray coded along idle, send, discard
  typedef enum logic [1:0] {
    MFT_TX_IDLE    = 2'h0,
    MFT_TX_SEND    = 2'h1,
    MFT_TX_DISCARD = 2'h3
  } mft_tx_state_t;
endpackage

/* File: mft_fifo.sv */
/*
  Simple synchronous FIFO carrying data plus start/end markers and error bits.
  Assumes the caller never writes when full nor reads when empty.
*/
`timescale 1ns/1ps
`default_nettype none
module mft_fifo
  import mft_pkg::*;
#(
  parameter int unsigned W  = 34,
  parameter int unsigned LG = MFT_DEPTH_LG
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             sys_rst_in,
  // Write side
  input  wire logic             wr_in,
  input  wire logic [W-1:0]     wdata_in,
  // Read side
  input  wire logic             rd_in,
  output logic      [W-1:0]     rdata_out,
  // Level in entries
  output logic      [LG:0]      level_out
);
  logic [W-1:0] mem [0:(1<<LG)-1];
  logic [LG:0]  wp_reg, wp_next, rp_reg, rp_next;

  // Pointer update
  always_comb begin
    wp_next = wr_in ? wp_reg + 1'b1 : wp_reg;
    rp_next = rd_in ? rp_reg + 1'b1 : rp_reg;
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge core_clk_in) begin
    if (wr_in) begin
      mem[wp_reg[LG-1:0]] <= wdata_in;
    end
  end

  assign rdata_out = mem[rp_reg[LG-1:0]];
  assign level_out = wp_reg - rp_reg;
endmodule
`default_nettype wire

/* File: mft_ctrl_asserts.sv */
/*
  Checker for the FIFO threshold control block, bound to mft_ctrl.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module mft_ctrl_chk
  import mft_pkg::*;
#(
  parameter int unsigned DW = MFT_DATA_W,
  parameter int unsigned LG = MFT_DEPTH_LG
) (
  // Clock and reset
  input  wire logic                 core_clk_in,
  input  wire logic                 sys_rst_in,
  // Receive side
  input  wire logic [LG:0]          rx_section_full_in,
  input  wire logic                 net_rx_valid_in,
  input  wire logic                 net_rx_eop_in,
  input  wire logic                 rcv_sink_accepting,
  input  wire logic                 rcv_data_valid_out,
  input  wire logic [DW-1:0]        rcv_data_out,
  input  wire logic                 rcv_end_of_packet_out,
  input  wire logic [MFT_ERR_W-1:0] rcv_error_out,
  input  wire logic                 rcv_data_available_out,
  // Pause and transmit side
  input  wire logic                 xoff_request_out,
  input  wire logic                 xon_request_out,
  input  wire logic                 xmt_accept_out,
  input  wire logic                 xmt_nearly_full_flag,
  input  wire logic                 net_tx_en_out,
  input  wire logic                 net_tx_err_out
);
  logic [7:0] eop_cnt_reg;
  logic [7:0] eop_cnt_next;
  // Frame ends seen on the network receive input and not yet taken at the user side
  always_comb begin
    eop_cnt_next = eop_cnt_reg;
    if (net_rx_valid_in && net_rx_eop_in) eop_cnt_next = eop_cnt_next + 8'h01;
    if (rcv_data_valid_out && rcv_sink_accepting && rcv_end_of_packet_out
        && eop_cnt_next != 8'h00) eop_cnt_next = eop_cnt_next - 8'h01;
  end
  // Count register
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) eop_cnt_reg <= 8'h00;
    else eop_cnt_reg <= eop_cnt_next;
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Underflow steps on the network side
  sequence uf_hit_s; net_tx_en_out && net_tx_err_out; endsequence
  sequence uf_end_s; !net_tx_en_out; endsequence
  sf_no_avail_a: assert property (rx_section_full_in == '0 |-> !rcv_data_available_out)
    else $error("data available raised in store-and-forward");
  sf_whole_frame_a: assert property ($rose(rcv_data_valid_out) && rx_section_full_in == '0
    |-> eop_cnt_reg != 8'h00)
    else $error("receive word shown before a whole frame was stored");
  rcv_hold_a: assert property (rcv_data_valid_out && !rcv_sink_accepting
    |=> rcv_data_valid_out && $stable(rcv_data_out))
    else $error("receive word lost before it was taken");
  trunc_eop_a: assert property (rcv_data_valid_out && rcv_error_out[MFT_ERR_TRUNC]
    |-> rcv_end_of_packet_out)
    else $error("truncation error without end of packet");
  trunc_inval_a: assert property (rcv_data_valid_out && rcv_error_out[MFT_ERR_TRUNC]
    |-> rcv_error_out[MFT_ERR_INVAL])
    else $error("truncated frame not marked invalid");
  tx_backpress_a: assert property (xmt_nearly_full_flag |-> !xmt_accept_out)
    else $error("transmit ready while nearly full");
  uf_stop_a: assert property (net_tx_err_out |-> uf_hit_s ##1 uf_end_s)
    else $error("underflow error not closing the frame");
  pause_excl_a: assert property (!(xoff_request_out && xon_request_out))
    else $error("pause on and off requested together");
endmodule
bind mft_ctrl mft_ctrl_chk #(.DW(DW), .LG(LG)) chk_i (
  .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .rx_section_full_in(rx_section_full_in),
  .net_rx_valid_in(net_rx_valid_in), .net_rx_eop_in(net_rx_eop_in),
  .rcv_sink_accepting(rcv_sink_accepting), .rcv_data_valid_out(rcv_data_valid_out),
  .rcv_data_out(rcv_data_out), .rcv_end_of_packet_out(rcv_end_of_packet_out),
  .rcv_error_out(rcv_error_out), .rcv_data_available_out(rcv_data_available_out),
  .xoff_request_out(xoff_request_out), .xon_request_out(xon_request_out),
  .xmt_accept_out(xmt_accept_out), .xmt_nearly_full_flag(xmt_nearly_full_flag),
  .net_tx_en_out(net_tx_en_out), .net_tx_err_out(net_tx_err_out));
`default_nettype wire

/* File: mft_net_model.sv */
/*
  Network receive driver: sends one frame of counting words per go pulse.
  Assumes the bench samples on the rising edge; words change on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module mft_net_model #(
  parameter int unsigned DW = 32
) (
  // Clock and command
  input  wire logic          core_clk_in,
  input  wire logic          go_in,
  input  wire logic [7:0]    len_in,
  input  wire logic [DW-1:0] base_in,
  input  wire logic          err_in,
  input  wire logic          stall_in,
  // Network receive stream
  output logic               busy_out,
  output logic               valid_out,
  output logic [DW-1:0]      data_out,
  output logic               sop_out,
  output logic               eop_out,
  output logic               err_out
);
  // Frame sender; idle lines show the inverse of the last word after a frame and toggle each cycle of a stall
  initial begin
    {busy_out, valid_out, sop_out, eop_out, err_out, data_out} = '0;
    forever begin
      @(posedge go_in);
      busy_out = 1'b1;
      for (int i = 0; i < int'(len_in); i++) begin
        @(negedge core_clk_in);
        while (stall_in && i == int'(len_in) - 1) begin
          valid_out = 1'b0;
          {data_out, sop_out, eop_out, err_out} = ~{data_out, sop_out, eop_out, err_out};
          @(negedge core_clk_in);
        end
        valid_out = 1'b1;
        data_out = base_in + DW'(i);
        sop_out = (i == 0);
        eop_out = (i == int'(len_in) - 1);
        err_out = err_in && eop_out;
      end
      @(negedge core_clk_in);
      valid_out = 1'b0;
      {data_out, sop_out, eop_out, err_out} = ~{data_out, sop_out, eop_out, err_out};
      busy_out = 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: test_mac_fifo_threshold_control.sv */
/*
  Self-checking bench for mft_ctrl with a network receive model.
  Assumes the package defaults: 32-bit words, 64-entry FIFOs.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module test_mac_fifo_threshold_control;
  import mft_pkg::*;
  logic clk, rst, drop, sink, go, stall, rerr, xv, xs, xe, busy, nv, nsop, neop, nerr;
  logic rv, rsop, reop, ravail, rne, rnf, xoff, xon, acc, xne, xnf, xrw, ten, terr;
  logic [6:0] lv [8];
  logic [7:0] len_r;
  logic [31:0] base, xd, nd, rd, td, txe;
  logic [3:0] rerr_o;
  logic [37:0] rxe, last_rx;
  logic [37:0] rxq [$];
  logic [31:0] txq [$];
  int error_cnt = 0, compares = 0, xoff_n = 0, xon_n = 0, uf_n = 0;
  logic rx_chk = 1'b1, tx_chk = 1'b1;
  mft_net_model #(.DW(32)) net_i (.core_clk_in(clk), .go_in(go), .len_in(len_r),
    .base_in(base), .err_in(rerr), .stall_in(stall), .busy_out(busy), .valid_out(nv),
    .data_out(nd), .sop_out(nsop), .eop_out(neop), .err_out(nerr));
  mft_ctrl uut (.core_clk_in(clk), .sys_rst_in(rst), .rx_almost_empty_in(lv[0]),
    .rx_almost_full_in(lv[1]), .rx_section_empty_in(lv[2]), .rx_section_full_in(lv[3]),
    .tx_almost_empty_in(lv[4]), .tx_almost_full_in(lv[5]), .tx_section_empty_in(lv[6]),
    .tx_section_full_in(lv[7]), .drop_errored_frames_ctl(drop), .net_rx_valid_in(nv),
    .net_rx_data_in(nd), .net_rx_sop_in(nsop), .net_rx_eop_in(neop), .net_rx_err_in(nerr),
    .rcv_sink_accepting(sink), .rcv_data_valid_out(rv), .rcv_data_out(rd),
    .rcv_start_of_packet_out(rsop), .rcv_end_of_packet_out(reop), .rcv_error_out(rerr_o),
    .rcv_data_available_out(ravail), .rcv_nearly_empty_flag(rne),
    .rcv_nearly_full_flag(rnf), .xoff_request_out(xoff), .xon_request_out(xon),
    .xmt_valid_in(xv), .xmt_data_in(xd), .xmt_sop_in(xs), .xmt_eop_in(xe),
    .xmt_accept_out(acc), .xmt_nearly_empty_flag(xne), .xmt_nearly_full_flag(xnf),
    .xmt_room_warning_out(xrw), .net_tx_en_out(ten), .net_tx_data_out(td),
    .net_tx_err_out(terr));
  // Clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Output watcher: takes the oldest note for each word that appears
  always @(posedge clk) begin
    xoff_n += int'(xoff);
    xon_n += int'(xon);
    uf_n += int'(ten && terr);
    if (rv && sink) begin
      last_rx = {rsop, reop, rerr_o, rd};
      rxe = rxq.size() != 0 ? rxq.pop_front() : 'x;
      if (rx_chk) `CHK(last_rx, rxe)
    end
    if (ten && !terr && tx_chk) begin
      txe = txq.size() != 0 ? txq.pop_front() : 'x;
      `CHK(td, txe)
    end
  end
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bound(input int n);
    if (n >= 300) begin
      error_cnt++;
      $display("unexpected timeout at %0t: got %h expected %h", $time, n, 0);
      give_verdict();
    end
  endtask
  // Receive frame: mode 0 expects no word out, 1 expects every word
  task automatic rx_frame(input int len, input logic err, input int mode, input logic hold);
    logic [31:0] b;
    int n;
    b = $urandom();
    for (int i = 0; i < len; i++)
      if (mode == 1)
        rxq.push_back({i == 0, i == len - 1, 4'h0, b + 32'(i)});
    @(negedge clk);
    {base, rerr, stall, len_r, go} = {b, err, hold, 8'(len), 1'b1};
    @(negedge clk);
    go = 1'b0;
    if (hold) begin
      repeat (10) @(negedge clk);
      `CHK(rv, 1'b0)
      stall = 1'b0;
    end
    for (n = 0; busy && n < 300; n++) @(negedge clk);
    bound(n);
  endtask
  task automatic drain;
    int n;
    for (n = 0; (rxq.size() != 0 || txq.size() != 0 || rv) && n < 300; n++) @(negedge clk);
    bound(n);
  endtask
  task automatic tx_word(input logic [31:0] d, input logic s, input logic e);
    int n;
    @(negedge clk);
    for (n = 0; !acc && n < 300; n++) begin
      xv = 1'b0;
      @(negedge clk);
    end
    bound(n);
    {xv, xd, xs, xe} = {1'b1, d, s, e};
  endtask
  // Transmit frame with a pause after hold_at words
  task automatic tx_frame(input int len, input int hold_at);
    logic [31:0] d;
    for (int i = 0; i < len; i++) begin
      if (i == hold_at) begin
        @(negedge clk);
        xv = 1'b0;
        repeat (6) @(negedge clk);
        `CHK(ten, 1'b0)
      end
      d = $urandom();
      txq.push_back(d);
      tx_word(d, i == 0, i == len - 1);
    end
    @(negedge clk);
    xv = 1'b0;
  endtask
  // Main sequence
  initial begin
    int n;
    {rst, drop, sink, go, stall, rerr, xv, xs, xe, xd, base, len_r} = {1'b1, 80'h0};
    lv = '{7'h02, 7'h04, 7'h08, 7'h04, 7'h01, 7'h04, 7'h08, 7'h04};
    void'($urandom(92));
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    `CHK(rne, 1'b1)
    `CHK(acc, 1'b1)
    `CHK(xrw, 1'b1)
    `CHK(ravail, 1'b0)
    $display("test reset_flags done");
    sink = 1'b1;
    rx_frame(6, 1'b0, 1, 1'b0);
    rx_frame(2, 1'b0, 1, 1'b0);
    drain();
    $display("test rx_basic done");
    sink = 1'b0;
    rx_frame(10, 1'b0, 1, 1'b0);
    `CHK(ravail, 1'b1)
    `CHK(rne, 1'b0)
    `CHK(xoff_n, 1)
    sink = 1'b1;
    drain();
    `CHK(xon_n, 1)
    $display("test rx_levels done");
    lv[3] = 7'h00;
    drop = 1'b1;
    rx_frame(5, 1'b0, 1, 1'b1);
    rx_frame(3, 1'b1, 0, 1'b0);
    repeat (8) @(negedge clk);
    drain();
    lv[3] = 7'h04;
    drop = 1'b0;
    $display("test rx_store_forward done");
    {sink, rx_chk} = 2'b00;
    rx_frame(70, 1'b0, 0, 1'b0);
    `CHK(rnf, 1'b1)
    sink = 1'b1;
    drain();
    `CHK(last_rx[36], 1'b1)
    `CHK(last_rx[32], 1'b1)
    `CHK(last_rx[35], 1'b1)
    rx_chk = 1'b1;
    $display("test rx_truncate done");
    tx_frame(6, 3);
    drain();
    lv[7] = 7'h00;
    tx_frame(8, 7);
    drain();
    $display("test tx_start done");
    tx_chk = 1'b0;
    for (int i = 0; i < 80; i++) begin
      @(negedge clk);
      if (!acc) break;
      {xv, xd, xs, xe} = {1'b1, $urandom(), i == 0, 1'b0};
    end
    `CHK(xnf, 1'b1)
    `CHK(acc, 1'b0)
    `CHK(xrw, 1'b0)
    {xv, lv[7]} = {1'b0, 7'h10};
    for (n = 0; uf_n == 0 && n < 300; n++) @(negedge clk);
    bound(n);
    @(negedge clk);
    `CHK(uf_n, 1)
    `CHK(ten, 1'b0)
    tx_word(32'h0, 1'b0, 1'b1);
    @(negedge clk);
    {xv, lv[7], tx_chk} = {1'b0, 7'h04, 1'b1};
    tx_frame(5, 5);
    drain();
    $display("test tx_underflow done");
    give_verdict();
  end
endmodule
`default_nettype wire
